// ### cartridge_transfer_mode_ctrl_test.sv
`default_nettype none
module cartridge_transfer_mode_ctrl_test
	import ctm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] T0 = 16'h7e11;
	localparam logic [15:0] B0 = 16'hb000;
	localparam logic [15:0] B1 = 16'hb111;
	logic clk_i = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, led_q = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, banks, rnd = 32'ha9a6229e;
	logic pready, pslverr, req, dir, bank, done, err, twa, cwa, led, alarm;
	logic [1:0] code, fail = 2'h3;
	logic [3:0] msw = 4'h0, psw = 4'h0, phase, ph_q = 4'h0;
	logic [3:0] bad [5] = '{4'h0, 4'h3, 4'h6, 4'h5, 4'h7};
	logic [7:0] lat = 8'h0;
	logic [15:0] term;
	logic [31:0] exp_v[$], exp_m[$];
	logic [3:0] exp_ph[$];
	int n_fail = 0, checks = 0, blinks = 0;
	always #20 clk_i = ~clk_i;
	ctm_top #(.BLINK_HALF_CYC(4)) DUT (.clk_i(clk_i), .arst_n_i(arst_n), .en_i(1'b1), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.mode_switch_bank_i(msw), .protect_switch_bank_i(psw), .op_req_o(req), .op_code_o(code), .op_dir_o(dir),
		.op_bank_o(bank), .op_done_i(done), .op_err_i(err), .term_wr_allow_o(twa), .cart_wr_allow_o(cwa),
		.phase_o(phase), .run_indicator_o(led), .alarm_o(alarm));
	ctm_flash_model #(.TERM_INIT(T0), .BANK0_INIT(B0), .BANK1_INIT(B1)) u_flash (.clk_i(clk_i), .rst_n_i(arst_n),
		.lat_i(lat), .fail_i(fail), .req_i(req), .code_i(code), .dir_i(dir), .bank_i(bank), .twa_i(twa),
		.cwa_i(cwa), .done_o(done), .err_o(err), .term_o(term), .banks_o(banks));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wrap_up();
		if (n_fail == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] v,
		input logic [31:0] m);
		int i;
		if (!w) begin
			exp_v.push_back(v);
			exp_m.push_back(m);
		end
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		for (i = 0; i < 50 && !(i > 0 && pready === 1'b1); i++) @(posedge clk_i);
		if (i == 50) begin
			n_fail++;
			wrap_up();
		end
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (psel && pen && pready && !pwr) begin
			cmp(prdata & exp_m.pop_front(), exp_v.pop_front());
		end
		if (phase !== ph_q && phase !== CTM_PH_NONE) begin
			cmp({28'h0, phase}, {28'h0, exp_ph.pop_front()});
		end
		if (led !== led_q && phase !== CTM_PH_DONE) blinks++;
		ph_q <= phase;
		led_q <= led;
	end
	task automatic run(input logic [3:0] m, input logic [3:0] p, input logic [1:0] f, input logic [7:0] l, input int n);
		for (int k = 0; k < n; k++) exp_ph.push_back(4'h1 << k);
		msw <= m;
		psw <= p;
		fail <= f;
		lat <= l;
		arst_n <= 1'b0;
		repeat (20) @(posedge clk_i);
		arst_n <= 1'b1;
		// capture lands 7 edges after release; later switch noise must be ignored
		repeat (12) @(posedge clk_i);
		rnd = lfsr(rnd);
		msw <= rnd[3:0] & 4'h7;
		psw <= rnd[7:4] & 4'h7;
		apb(1'b0, CTM_SWITCH_OFS, 32'h0, {24'h0, p, m}, 32'hff);
		blinks = 0;
	endtask
	task automatic fin(input logic [31:0] st, input logic [31:0] m, input logic [15:0] t, input logic [31:0] b);
		int i;
		for (i = 0; i < 3000 && phase !== CTM_PH_DONE && alarm !== 1'b1; i++) @(posedge clk_i);
		if (i == 3000) begin
			n_fail++;
			wrap_up();
		end
		repeat (30) @(posedge clk_i);
		apb(1'b0, CTM_STATUS_OFS, 32'h0, st, m);
		cmp({31'h0, alarm}, {31'h0, |(st & 32'hf0)});
		cmp({16'h0, term}, {16'h0, t});
		cmp(banks, b);
		cmp(exp_ph.size(), 32'h0);
	endtask
	initial begin
		run(4'h2, 4'h6, 2'h3, 8'd20, 4);
		fin(32'h308, 32'hfff, T0, {T0, B0});
		cmp(blinks > 0, 32'h1);
		run(4'h1, 4'h1, 2'h3, 8'd0, 4);
		fin(32'h008, 32'hfff, B0, {B1, B0});
		for (int k = 0; k < 5; k++) begin
			run(bad[k], 4'h3, 2'h3, 8'd0, 0);
			fin(32'h10, 32'hf0, T0, {B1, B0});
		end
		run(4'h2, 4'h5, 2'h3, 8'd0, 0);
		fin(32'h20, 32'hf0, T0, {B1, B0});
		run(4'h1, 4'h2, 2'h3, 8'd0, 0);
		fin(32'h20, 32'hf0, T0, {B1, B0});
		for (int f = 0; f < 3; f++) begin
			run(4'h2, 4'h2, f[1:0], 8'd3, f + 1);
			fin(f == 2 ? 32'h80 : 32'h40, 32'hf0, T0, f == 2 ? {B1, T0} : {B1, B0});
		end
		run(4'h4, 4'h3, 2'h3, 8'd2, 0);
		rnd = lfsr(rnd);
		apb(1'b1, CTM_CTRL_OFS, rnd & 32'hfffffff3, 32'h0, 32'h0);
		apb(1'b0, CTM_CTRL_OFS, 32'h0, rnd & 32'h3, 32'hf);
		apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff);
		cmp({31'h0, e}, 32'h1);
		exp_ph = '{4'h1, 4'h2, 4'h4, 4'h8};
		apb(1'b1, CTM_CTRL_OFS, 32'h3, 32'h0, 32'h0);
		apb(1'b1, CTM_CTRL_OFS, 32'h7, 32'h0, 32'h0);
		fin(32'h708, 32'hfff, T0, {T0, B0});
		run(4'h4, 4'h1, 2'h3, 8'd0, 0);
		apb(1'b1, CTM_CTRL_OFS, 32'h1, 32'h0, 32'h0);
		apb(1'b1, CTM_CTRL_OFS, 32'h5, 32'h0, 32'h0);
		repeat (10) @(posedge clk_i);
		cmp({31'h0, alarm}, 32'h1);
		apb(1'b1, CTM_CTRL_OFS, 32'h8, 32'h0, 32'h0);
		repeat (5) @(posedge clk_i);
		cmp({31'h0, alarm}, 32'h0);
		apb(1'b0, CTM_STATUS_OFS, 32'h0, 32'h400, 32'h4f0);
		wrap_up();
	end
endmodule // cartridge_transfer_mode_ctrl_test
`default_nettype wire

// ### ctm_blinker.sv
`default_nettype none
module ctm_blinker #(
	parameter int unsigned HALF_CYC = 6250000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic blink_i,
	input wire logic steady_i,
	output logic led_o
);
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	logic [CW-1:0] cnt_q;
	logic phase_q;
	wire wrap = (cnt_q == CW'(HALF_CYC - 1));

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			phase_q <= 1'b0;
			led_o <= 1'b0;
		end else if (en_i) begin
			// counter restarts outside blinking so every blink starts with a full lit half
			cnt_q <= (!blink_i || wrap) ? '0 : cnt_q + CW'(1);
			phase_q <= !blink_i ? 1'b1 : (wrap ? ~phase_q : phase_q);
			led_o <= steady_i | (blink_i & phase_q);
		end
	end
endmodule // ctm_blinker
`default_nettype wire

// ### ctm_cfg_if.sv
`default_nettype none
interface ctm_cfg_if;
	logic valid;
	logic auto_load_sel;
	logic auto_save_sel;
	logic manual_xfer_sel;
	logic term_wr_en;
	logic cart_wr_en;
	logic auto_bank_sel;
	logic [7:0] raw;
	modport src (output valid, auto_load_sel, auto_save_sel, manual_xfer_sel, term_wr_en, cart_wr_en,
		auto_bank_sel, raw);
	modport dst (input valid, auto_load_sel, auto_save_sel, manual_xfer_sel, term_wr_en, cart_wr_en,
		auto_bank_sel, raw);
endinterface
`default_nettype wire

// ### ctm_flash_model.sv
`default_nettype none
module ctm_flash_model
	import ctm_pkg::*;
#(
	parameter logic [15:0] TERM_INIT = 16'h0001,
	parameter logic [15:0] BANK0_INIT = 16'h0002,
	parameter logic [15:0] BANK1_INIT = 16'h0003
) (
	// clock, reset, fault setup
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] lat_i,
	input wire logic [1:0] fail_i,
	// operation port
	input wire logic req_i,
	input wire logic [1:0] code_i,
	input wire logic dir_i,
	input wire logic bank_i,
	input wire logic twa_i,
	input wire logic cwa_i,
	output logic done_o,
	output logic err_o,
	// stored images
	output logic [15:0] term_o,
	output logic [31:0] banks_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q;
	logic [15:0] bank_q [2];
	logic wr_ok;
	assign banks_o = {bank_q[1], bank_q[0]};
	// a locked destination refuses the write like real flash
	assign wr_ok = dir_i ? cwa_i : twa_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= 8'h0;
			done_o <= 1'b0;
			err_o <= 1'b0;
			term_o <= TERM_INIT;
			bank_q[0] <= BANK0_INIT;
			bank_q[1] <= BANK1_INIT;
		end else begin
			done_o <= 1'b0;
			// meaningless between answers, so kept moving
			err_o <= ~err_o;
			if (req_i && !done_o) begin
				cnt_q <= cnt_q + 8'h1;
				if (cnt_q >= lat_i) begin
					cnt_q <= 8'h0;
					done_o <= 1'b1;
					err_o <= code_i == fail_i || (code_i == CTM_OP_WRITE && !wr_ok);
					if (code_i == CTM_OP_WRITE && wr_ok && fail_i != CTM_OP_WRITE) begin
						if (dir_i == CTM_DIR_SAVE) begin
							bank_q[bank_i] <= term_o;
						end else begin
							term_o <= bank_q[bank_i];
						end
					end
				end
			end
		end
	end
endmodule // ctm_flash_model
`default_nettype wire

// ### ctm_pkg.sv
`default_nettype none
package ctm_pkg;
	// apb register byte offsets
	localparam logic [11:0] CTM_CTRL_OFS = 12'h000;
	localparam logic [11:0] CTM_STATUS_OFS = 12'h004;
	localparam logic [11:0] CTM_SWITCH_OFS = 12'h008;
	// control register fields
	localparam int CTM_CTRL_DIR_BIT = 0;
	localparam int CTM_CTRL_BANK_BIT = 1;
	localparam int CTM_CTRL_EXEC_BIT = 2;
	localparam int CTM_CTRL_ACK_BIT = 3;
	localparam logic CTM_CTRL_DIR_RST = 1'b0;
	localparam logic CTM_CTRL_BANK_RST = 1'b0;
	// status register fields
	localparam int CTM_ST_PHASE_LSB = 0;
	localparam int CTM_ST_MODE_ERR_BIT = 4;
	localparam int CTM_ST_PROT_ERR_BIT = 5;
	localparam int CTM_ST_FLASH_ERR_BIT = 6;
	localparam int CTM_ST_VERIFY_ERR_BIT = 7;
	localparam int CTM_ST_DIR_BIT = 8;
	localparam int CTM_ST_BANK_BIT = 9;
	localparam int CTM_ST_MANUAL_BIT = 10;
	localparam int CTM_ST_IDLE_BIT = 11;
	// switch positions inside each four-switch bank
	localparam int CTM_SW_AUTO_LOAD = 0;
	localparam int CTM_SW_AUTO_SAVE = 1;
	localparam int CTM_SW_MANUAL = 2;
	localparam int CTM_SW_TERM_WR = 0;
	localparam int CTM_SW_CART_WR = 1;
	localparam int CTM_SW_BANK = 2;
	// transfer direction
	localparam logic CTM_DIR_LOAD = 1'b0;
	localparam logic CTM_DIR_SAVE = 1'b1;
	// flash operation codes
	localparam logic [1:0] CTM_OP_INIT = 2'h0;
	localparam logic [1:0] CTM_OP_WRITE = 2'h1;
	localparam logic [1:0] CTM_OP_VERIFY = 2'h2;
	// reported phases, one-hot
	localparam logic [3:0] CTM_PH_NONE = 4'h0;
	localparam logic [3:0] CTM_PH_PREP = 4'h1;
	localparam logic [3:0] CTM_PH_XMIT = 4'h2;
	localparam logic [3:0] CTM_PH_VERIFY = 4'h4;
	localparam logic [3:0] CTM_PH_DONE = 4'h8;
	// timing
	localparam int unsigned CTM_CLK_KHZ = 25000;
	localparam int unsigned CTM_BLINK_HALF_MS = 250;
	localparam int unsigned CTM_BLINK_HALF_CYC = CTM_BLINK_HALF_MS * CTM_CLK_KHZ;
	localparam int unsigned CTM_SETTLE_CYC = 4;
	typedef enum logic [7:0] {
		ST_WAIT = 8'h01,
		ST_CHECK = 8'h02,
		ST_MAN = 8'h04,
		ST_PREP = 8'h08,
		ST_XMIT = 8'h10,
		ST_VERIFY = 8'h20,
		ST_DONE = 8'h40,
		ST_ERROR = 8'h80
	} ctm_state_e;
endpackage
`default_nettype wire

// ### ctm_sw_capture.sv
`default_nettype none
module ctm_sw_capture
	import ctm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic [3:0] mode_switch_bank_i,
	input wire logic [3:0] protect_switch_bank_i,
	ctm_cfg_if.src cfg
);
	logic [2:0] settle_q;
	logic valid_q;
	logic [7:0] sw_q;
	wire settle_done = (settle_q == 3'(CTM_SETTLE_CYC));

	// the banks are caught once, a few cycles after reset release, then frozen
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_q <= 3'h0;
			valid_q <= 1'b0;
			sw_q <= 8'h00;
		end else if (en_i && !valid_q) begin
			if (settle_done) begin
				valid_q <= 1'b1;
				sw_q <= {protect_switch_bank_i, mode_switch_bank_i};
			end else begin
				settle_q <= settle_q + 3'h1;
			end
		end
	end

	assign cfg.valid = valid_q;
	assign cfg.raw = sw_q;
	assign cfg.auto_load_sel = sw_q[CTM_SW_AUTO_LOAD];
	assign cfg.auto_save_sel = sw_q[CTM_SW_AUTO_SAVE];
	assign cfg.manual_xfer_sel = sw_q[CTM_SW_MANUAL];
	assign cfg.term_wr_en = sw_q[4 + CTM_SW_TERM_WR];
	assign cfg.cart_wr_en = sw_q[4 + CTM_SW_CART_WR];
	assign cfg.auto_bank_sel = sw_q[4 + CTM_SW_BANK];
endmodule // ctm_sw_capture
`default_nettype wire

// ### ctm_top.sv
// Functional notes
// - mode and write protection come only from captured switch banks
// - auto load copies cartridge into terminal
// - auto save copies terminal into cartridge
// - manual mode takes direction, bank from panel
// - terminal writes only with term_wr_en on
// - cartridge writes only with cart_wr_en on
// - auto transfers use bank auto_bank_sel
// - cartridge has two independent full-image banks
// - mode error unless mode switches one-hot
// - protect error when destination write disabled
// - auto save overwrites only selected bank
// - auto save leaves terminal data untouched
// - auto load fully replaces terminal data
// - phases preparing, transmitting, verifying, finished
// - indicator blinks while busy, steady when finished
// - errors latch with alarm, manual protect acknowledgeable
// - verify pass after write, verify error
// - flash error on init or write failure
`default_nettype none
module ctm_top
	import ctm_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = CTM_BLINK_HALF_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic en_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// configuration switch banks
	input wire logic [3:0] mode_switch_bank_i,
	input wire logic [3:0] protect_switch_bank_i,
	// flash operation port
	output logic op_req_o,
	output logic [1:0] op_code_o,
	output logic op_dir_o,
	output logic op_bank_o,
	input wire logic op_done_i,
	input wire logic op_err_i,
	// destination write gates
	output logic term_wr_allow_o,
	output logic cart_wr_allow_o,
	// operator feedback
	output logic [3:0] phase_o,
	output logic run_indicator_o,
	output logic alarm_o
);
	logic [1:0] rst_sync_q;
	wire rst_n = rst_sync_q[1];

	// release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// captured switches
	ctm_cfg_if cfg ();

	ctm_sw_capture u_capture (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.en_i(en_i),
		.mode_switch_bank_i(mode_switch_bank_i),
		.protect_switch_bank_i(protect_switch_bank_i),
		.cfg(cfg)
	);

	// apb decode
	wire apb_setup = psel_i & ~penable_i;
	wire apb_fire = psel_i & penable_i & pready_o;
	wire apb_wr = apb_fire & pwrite_i;
	wire hit_ctrl = (paddr_i == CTM_CTRL_OFS);
	wire hit_status = (paddr_i == CTM_STATUS_OFS);
	wire hit_switch = (paddr_i == CTM_SWITCH_OFS);
	wire hit_any = hit_ctrl | hit_status | hit_switch;
	// writes to the read-only words are dropped without an error
	wire wr_ctrl = apb_wr & hit_ctrl & ~pslverr_o;
	wire exec_pulse = wr_ctrl & pwdata_i[CTM_CTRL_EXEC_BIT];
	wire ack_pulse = wr_ctrl & pwdata_i[CTM_CTRL_ACK_BIT];

	// control state
	ctm_state_e state_q;
	ctm_state_e state_d;
	logic man_dir_q;
	logic man_bank_q;
	logic dir_q;
	logic dir_d;
	logic bank_q;
	logic bank_d;
	logic manual_q;
	logic mode_err_q;
	logic prot_err_q;
	logic flash_err_q;
	logic verify_err_q;

	// mode decode from captured switches only
	wire [2:0] mode_vec = {cfg.manual_xfer_sel, cfg.auto_save_sel, cfg.auto_load_sel};
	wire mode_onehot = (mode_vec == 3'b001) | (mode_vec == 3'b010) | (mode_vec == 3'b100);
	// the reserved fourth switches are not decoded at all
	wire chk_dir = cfg.auto_save_sel ? CTM_DIR_SAVE : CTM_DIR_LOAD;
	wire chk_bank = cfg.auto_bank_sel;
	wire man_dest_ok = (man_dir_q == CTM_DIR_SAVE) ? cfg.cart_wr_en : cfg.term_wr_en;
	wire auto_dest_ok = (chk_dir == CTM_DIR_SAVE) ? cfg.cart_wr_en : cfg.term_wr_en;
	// a done with no request outstanding is ignored
	wire op_ack = op_req_o & op_done_i;

	// error events
	wire set_mode_err = (state_q == ST_CHECK) & ~mode_onehot;
	wire set_prot_auto = (state_q == ST_CHECK) & mode_onehot & ~cfg.manual_xfer_sel & ~auto_dest_ok;
	wire set_prot_man = (state_q == ST_MAN) & exec_pulse & ~man_dest_ok;
	wire set_flash_err = ((state_q == ST_PREP) | (state_q == ST_XMIT)) & op_ack & op_err_i;
	wire set_verify_err = (state_q == ST_VERIFY) & op_ack & op_err_i;
	// only a protect error raised in manual mode may be acknowledged
	wire clr_prot = (state_q == ST_ERROR) & manual_q & ack_pulse & ~mode_err_q & ~flash_err_q & ~verify_err_q;

	// one-hot states; an illegal code falls into the error state
	always_comb begin
		state_d = state_q;
		dir_d = dir_q;
		bank_d = bank_q;
		case (state_q)
			ST_WAIT: begin
				if (cfg.valid) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (!mode_onehot) begin
					state_d = ST_ERROR;
				end else if (cfg.manual_xfer_sel) begin
					state_d = ST_MAN;
				end else if (!auto_dest_ok) begin
					state_d = ST_ERROR;
				end else begin
					dir_d = chk_dir;
					bank_d = chk_bank;
					state_d = ST_PREP;
				end
			end
			ST_MAN: begin
				if (exec_pulse) begin
					dir_d = man_dir_q;
					bank_d = man_bank_q;
					state_d = man_dest_ok ? ST_PREP : ST_ERROR;
				end
			end
			ST_PREP: begin
				if (op_ack) begin
					state_d = op_err_i ? ST_ERROR : ST_XMIT;
				end
			end
			ST_XMIT: begin
				if (op_ack) begin
					state_d = op_err_i ? ST_ERROR : ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				if (op_ack) begin
					state_d = op_err_i ? ST_ERROR : ST_DONE;
				end
			end
			ST_DONE: begin
				state_d = ST_DONE;
			end
			ST_ERROR: begin
				if (clr_prot) begin
					state_d = ST_MAN;
				end
			end
			default: begin
				state_d = ST_ERROR;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_WAIT;
		end else if (en_i) begin
			state_q <= state_d;
		end
	end

	// selection of the transfer under way, kept for status and the op port
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= CTM_DIR_LOAD;
			bank_q <= 1'b0;
		end else if (en_i) begin
			dir_q <= dir_d;
			bank_q <= bank_d;
		end
	end

	// manual mode is known once the checks pass and never forgotten
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			manual_q <= 1'b0;
		end else if (en_i) begin
			manual_q <= manual_q | ((state_q == ST_CHECK) & cfg.manual_xfer_sel & mode_onehot);
		end
	end

	// sticky error flags; a set in the same cycle as the acknowledge wins
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_err_q <= 1'b0;
			prot_err_q <= 1'b0;
			flash_err_q <= 1'b0;
			verify_err_q <= 1'b0;
		end else if (en_i) begin
			mode_err_q <= mode_err_q | set_mode_err;
			prot_err_q <= set_prot_auto | set_prot_man | (prot_err_q & ~clr_prot);
			flash_err_q <= flash_err_q | set_flash_err;
			verify_err_q <= verify_err_q | set_verify_err;
		end
	end

	// outputs are registered from the next state so they line up with it
	wire busy_d = (state_d == ST_PREP) | (state_d == ST_XMIT) | (state_d == ST_VERIFY);
	wire [1:0] code_d = (state_d == ST_XMIT) ? CTM_OP_WRITE : ((state_d == ST_VERIFY) ? CTM_OP_VERIFY : CTM_OP_INIT);
	// request drops for one cycle after each done so phases stay distinct
	wire req_d = busy_d & ~op_ack;
	// write gates open only in the write phase, never before the checks
	wire xmit_d = (state_d == ST_XMIT);
	wire term_allow_d = xmit_d & (dir_d == CTM_DIR_LOAD) & cfg.term_wr_en;
	wire cart_allow_d = xmit_d & (dir_d == CTM_DIR_SAVE) & cfg.cart_wr_en;
	// phase holds at none outside a transfer, including errors
	wire [3:0] phase_d = (state_d == ST_PREP) ? CTM_PH_PREP :
		(state_d == ST_XMIT) ? CTM_PH_XMIT :
		(state_d == ST_VERIFY) ? CTM_PH_VERIFY :
		(state_d == ST_DONE) ? CTM_PH_DONE : CTM_PH_NONE;
	// the alarm stands for the whole error state, not just its entry
	wire err_d = (state_d == ST_ERROR);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			op_req_o <= 1'b0;
			op_code_o <= CTM_OP_INIT;
			op_dir_o <= CTM_DIR_LOAD;
			op_bank_o <= 1'b0;
		end else if (en_i) begin
			op_req_o <= req_d;
			op_code_o <= code_d;
			op_dir_o <= dir_d;
			op_bank_o <= bank_d;
		end
	end

	// destination write gates
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			term_wr_allow_o <= 1'b0;
			cart_wr_allow_o <= 1'b0;
		end else if (en_i) begin
			term_wr_allow_o <= term_allow_d;
			cart_wr_allow_o <= cart_allow_d;
		end
	end

	// operator feedback
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_o <= CTM_PH_NONE;
			alarm_o <= 1'b0;
		end else if (en_i) begin
			phase_o <= phase_d;
			alarm_o <= err_d;
		end
	end

	// run indicator: blink while busy or in error, lit once finished
	ctm_blinker #(
		.HALF_CYC(BLINK_HALF_CYC)
	) u_blink (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.en_i(en_i),
		.blink_i(busy_d | err_d),
		.steady_i(state_d == ST_DONE),
		.led_o(run_indicator_o)
	);

	// panel selections for manual mode
	// execute acts on the selection already held, so set direction and bank first
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			man_dir_q <= CTM_CTRL_DIR_RST;
			man_bank_q <= CTM_CTRL_BANK_RST;
		end else if (en_i && wr_ctrl) begin
			man_dir_q <= pwdata_i[CTM_CTRL_DIR_BIT];
			man_bank_q <= pwdata_i[CTM_CTRL_BANK_BIT];
		end
	end

	// read mux
	wire [31:0] rd_ctrl = {30'h0, man_bank_q, man_dir_q};
	// phase comes from its register so status agrees with phase_o
	wire [31:0] rd_status = {20'h0, (state_q == ST_WAIT), manual_q, bank_q, dir_q,
		verify_err_q, flash_err_q, prot_err_q, mode_err_q, phase_o};
	wire [31:0] rd_switch = {24'h0, cfg.raw};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : (hit_status ? rd_status : (hit_switch ? rd_switch : 32'h0));

	// no wait state: data and ready are latched in the setup cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (en_i) begin
			pready_o <= apb_setup;
			pslverr_o <= apb_setup & ~hit_any;
		end
	end

	// read data only on reads, zero otherwise
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0;
		end else if (en_i) begin
			prdata_o <= (apb_setup & ~pwrite_i) ? rd_mux : 32'h0;
		end
	end
endmodule // ctm_top
`default_nettype wire

// ### ctm_top_sva.sv
`default_nettype none
module ctm_top_sva
	import ctm_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic op_req_o,
	input wire logic [1:0] op_code_o,
	input wire logic op_dir_o,
	input wire logic op_bank_o,
	input wire logic op_done_i,
	input wire logic op_err_i,
	input wire logic term_wr_allow_o,
	input wire logic cart_wr_allow_o,
	input wire logic [3:0] phase_o,
	input wire logic run_indicator_o,
	input wire logic alarm_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_TERM_GATE: assert property (term_wr_allow_o |-> op_dir_o == CTM_DIR_LOAD && phase_o == CTM_PH_XMIT)
		else $error("terminal gate open");
	AST_CART_GATE: assert property (cart_wr_allow_o |-> op_dir_o == CTM_DIR_SAVE && phase_o == CTM_PH_XMIT)
		else $error("cartridge gate open");
	AST_CODE_PHASE: assert property (op_req_o |-> phase_o == (4'h1 << op_code_o))
		else $error("op code off phase");
	AST_PHASE_STEP: assert property (phase_o != $past(phase_o) && phase_o != CTM_PH_NONE |->
		phase_o == ($past(phase_o) << 1) || (phase_o == CTM_PH_PREP && $past(phase_o) == CTM_PH_NONE))
		else $error("phase skipped");
	AST_REQ_HOLD: assert property (op_req_o && !op_done_i |=> op_req_o && $stable(op_code_o) && $stable(op_bank_o))
		else $error("request dropped");
	AST_ERR_ALARM: assert property (op_req_o && op_done_i && op_err_i |-> ##[1:4] alarm_o)
		else $error("no alarm on fault");
	AST_ERR_QUIET: assert property (alarm_o |-> !op_req_o && !term_wr_allow_o && !cart_wr_allow_o)
		else $error("activity in error");
	AST_DONE_STEADY: assert property (phase_o == CTM_PH_DONE [*3] |-> run_indicator_o && !alarm_o)
		else $error("indicator not steady");
	AST_APB_ANSWER: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("apb answer");
endmodule // ctm_top_sva
bind ctm_top ctm_top_sva u_sva (.*);
`default_nettype wire
